// ### slprm_pkg.sv
/*
 mode-control constants of the low-power and restart sequencer.
 assumes a 50 MHz system clock and a host that decodes spi commands upstream.
*/
// Notes on behaviour
// - in stop, writes are ignored and flag spi error, except listed commands
// - in stop, wake events raise interrupt, mode unchanged
// - in stop, main rail on, all other settings held as in normal
// - wake flags still set on stop entry raise interrupt
// - stop to sleep request flags spi error and goes to restart
// - measurement select blocks hv wake pin and general pin as wake sources
// - sleep wake goes via restart to normal and records the source
// - on sleep entry can on or receive-only becomes wake-capable unless off
// - sleep with no wake source flags spi error and restarts; cyclic wake counts
// - wake flags set on sleep entry wake at once via restart
// - restart on undervoltage, or overvoltage with reset enabled and config bit 1
// - first bad watchdog trigger restarts in configs 1,3,4, else fail-safe
// - restart on wake from sleep or fail-safe, or thermal release
// - restart moves to normal by itself and clears mode bits
// - reset low on restart entry, high after delay; long window starts then
// - restart reloads watchdog period code with default 100
// - fail output set on listed failures, never cleared by leaving restart
// - restart disables aux rail, general switch off, can wake-capable unless off
// - restart ignores all spi traffic
// - device status reads 01 after fault restart, 10 after sleep wake
// - watchdog failure count 01 then 10; supply flags set for supply restarts
// - mode code 11 soft resets to init, locked bits kept
package slprm_pkg;

    // =====================================================
    // modes and codes
    typedef enum logic [5:0] {
        SLPRM_INIT    = 6'h01,
        SLPRM_NORMAL  = 6'h02,
        SLPRM_STOP    = 6'h04,
        SLPRM_SLEEP   = 6'h08,
        SLPRM_RESTART = 6'h10,
        SLPRM_FSAFE   = 6'h20
    } slprm_mode_t;

    localparam logic [1:0] SLPRM_REQ_NORMAL = 2'h0;
    localparam logic [1:0] SLPRM_REQ_SLEEP  = 2'h1;
    localparam logic [1:0] SLPRM_REQ_STOP   = 2'h2;
    localparam logic [1:0] SLPRM_REQ_SOFT   = 2'h3;

    localparam logic [1:0] SLPRM_CAN_OFF  = 2'h0;
    localparam logic [1:0] SLPRM_CAN_WAKE = 2'h1;
    localparam logic [1:0] SLPRM_CAN_RXO  = 2'h2;
    localparam logic [1:0] SLPRM_CAN_ON   = 2'h3;

    localparam logic [1:0] SLPRM_DEV_NONE  = 2'h0;
    localparam logic [1:0] SLPRM_DEV_FAULT = 2'h1;
    localparam logic [1:0] SLPRM_DEV_WAKE  = 2'h2;

    localparam logic [1:0] SLPRM_WDF_ONE = 2'h1;
    localparam logic [1:0] SLPRM_WDF_TWO = 2'h2;

    localparam logic [2:0] SLPRM_WD_PER_DEFAULT = 3'h4;
    localparam int         SLPRM_NSRC           = 4;
    // wake source bit positions
    localparam int SLPRM_SRC_CAN   = 0;
    localparam int SLPRM_SRC_HV    = 1;
    localparam int SLPRM_SRC_GP    = 2;
    localparam int SLPRM_SRC_TIMER = 3;

    // =====================================================
    // timing
    localparam int SLPRM_CLK_MHZ  = 50;
    localparam int SLPRM_TRD_US   = 10;
    localparam int SLPRM_TRD_CYC  = SLPRM_TRD_US * SLPRM_CLK_MHZ;

endpackage : slprm_pkg

// ### slprm_delay.sv
/*
 reset delay counter: counts while run is high, done pulses at terminal.
 assumes run drops once the sequencer leaves restart.
*/
`timescale 1ns/1ns
module slprm_delay import slprm_pkg::*; #(
    parameter int CYC = SLPRM_TRD_CYC
) (
    // system
    input  wire logic clk_sys,
    input  wire logic nrst,
    // control
    input  wire logic run,
    output logic      done
);
    logic [15:0] cnt;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt  <= 16'h0000;
            done <= 1'b0;
        end else if (!run) begin
            cnt  <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= (cnt == 16'(CYC - 2));
            if (cnt != 16'(CYC - 1)) begin
                cnt <= cnt + 16'h0001;
            end
        end
    end
endmodule : slprm_delay

// ### slprm_wake.sv
/*
 wake source qualifier: masks enables and measurement mode, sets sticky flags.
 assumes wake inputs are one-cycle event pulses.
*/
`timescale 1ns/1ns
module slprm_wake import slprm_pkg::*; (
    // system
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    // events and config
    input  wire logic [SLPRM_NSRC-1:0]    wake_evt,
    input  wire logic [SLPRM_NSRC-1:0]    wake_en,
    input  wire logic                     measure_function_select,
    input  wire logic                     armed,
    input  wire logic                     flag_clear,
    // results
    output logic      [SLPRM_NSRC-1:0]    wake_hit,
    output logic      [SLPRM_NSRC-1:0]    wake_flags
);
    logic [SLPRM_NSRC-1:0] en_eff;

    always_comb begin
        en_eff = wake_en;
        if (measure_function_select) begin
            en_eff[SLPRM_SRC_HV] = 1'b0;
            en_eff[SLPRM_SRC_GP] = 1'b0;
        end
    end

    assign wake_hit = wake_evt & en_eff & {SLPRM_NSRC{armed}};

    // set beats clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wake_flags <= '0;
        end else begin
            wake_flags <= (flag_clear ? '0 : wake_flags) | wake_hit;
        end
    end

    AST_MEAS_BLOCK: assert property (@(posedge clk_sys) disable iff (!nrst)
        measure_function_select |-> !wake_hit[SLPRM_SRC_HV] && !wake_hit[SLPRM_SRC_GP])
        else $error("measure mode let a pin wake");
endmodule : slprm_wake

// ### slprm_seq.sv
/*
 low-power and restart mode sequencer of the basis chip.
 assumes decoded spi requests arrive as one-cycle pulses and analog
 monitors give synchronous level or pulse indications.
*/
`timescale 1ns/1ns
module slprm_seq import slprm_pkg::*; #(
    parameter int TRD_CYC = SLPRM_TRD_CYC
) (
    // system
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    // decoded spi requests
    input  wire logic                  spi_valid,
    input  wire logic                  spi_write,
    input  wire logic                  spi_is_mode,
    input  wire logic [1:0]            spi_mode_code,
    input  wire logic                  spi_wd_refresh,
    input  wire logic                  spi_status_access,
    input  wire logic                  spi_status_clear,
    // configuration
    input  wire logic [SLPRM_NSRC-1:0] wake_en,
    input  wire logic                  cyclic_wake_en,
    input  wire logic                  measure_function_select,
    input  wire logic                  main_rail_overvoltage_reset_enable,
    input  wire logic                  config_state_bit,
    input  wire logic                  cfg1_bit,
    input  wire logic                  fo_configured,
    input  wire logic                  gp_switch_mode,
    input  wire logic                  aux_rail_cfg,
    input  wire logic [1:0]            can_mode_cfg,
    // events
    input  wire logic [SLPRM_NSRC-1:0] wake_evt,
    input  wire logic                  uv_evt,
    input  wire logic                  ov_evt,
    input  wire logic                  watchdog_failure_count_evt,
    input  wire logic                  thermal_shutdown_level2_release,
    // outputs
    output slprm_mode_t                mode,
    output logic                       reset_output_n,
    output logic                       interrupt_output_n,
    output logic                       main_supply_rail,
    output logic                       aux_supply_rail,
    output logic [1:0]                 can_mode,
    output logic                       gp_switch_on,
    output logic                       watchdog_enable,
    output logic                       spi_enable,
    output logic                       long_window_start,
    output logic [2:0]                 watchdog_period,
    output logic                       spi_fail,
    output logic                       fail_output,
    output logic [1:0]                 device_status_field,
    output logic [1:0]                 watchdog_failure_count,
    output logic                       main_rail_undervoltage_flag,
    output logic                       main_rail_overvoltage_flag,
    output logic [1:0]                 mode_bits,
    output logic                       soft_reset,
    output logic [SLPRM_NSRC-1:0]      wake_status_reg_a
);
    // =====================================================
    // helpers
    slprm_mode_t           next_mode;
    logic [SLPRM_NSRC-1:0] wake_hit;
    logic [SLPRM_NSRC-1:0] wake_flags;
    logic                  delay_done;
    logic                  in_restart;
    logic                  allowed;
    logic                  req_sleep;
    logic                  req_stop;
    logic                  req_norm;
    logic                  req_soft;
    logic                  any_src;
    logic                  wd_to_fsafe;
    logic                  ov_restart;
    logic                  ov_fsafe;
    logic                  enter_fault;
    logic                  enter_wake;

    function automatic logic mode_req(input logic [1:0] code, input logic [1:0] want);
        mode_req = spi_valid && spi_write && spi_is_mode && code == want;
    endfunction : mode_req

    assign in_restart = (mode == SLPRM_RESTART);
    assign req_sleep  = !in_restart && mode_req(spi_mode_code, SLPRM_REQ_SLEEP);
    assign req_stop   = !in_restart && mode_req(spi_mode_code, SLPRM_REQ_STOP);
    assign req_norm   = !in_restart && mode_req(spi_mode_code, SLPRM_REQ_NORMAL);
    assign req_soft   = !in_restart && mode_req(spi_mode_code, SLPRM_REQ_SOFT);
    assign allowed    = req_norm || req_soft || spi_wd_refresh || spi_status_access;
    assign any_src    = (|wake_en) || cyclic_wake_en;
    assign wd_to_fsafe = !config_state_bit
                         && (cfg1_bit || watchdog_failure_count == SLPRM_WDF_ONE);
    assign ov_restart = ov_evt && main_rail_overvoltage_reset_enable && config_state_bit;
    assign ov_fsafe   = ov_evt && main_rail_overvoltage_reset_enable && !config_state_bit;
    assign enter_fault = (mode == SLPRM_NORMAL || mode == SLPRM_STOP || mode == SLPRM_INIT)
                         && (uv_evt || ov_restart || (watchdog_failure_count_evt && !wd_to_fsafe));
    assign enter_wake = (mode == SLPRM_SLEEP && |wake_hit)
                        || (mode == SLPRM_FSAFE && (|wake_hit || thermal_shutdown_level2_release));

    slprm_wake u_wake (
        .clk_sys                 (clk_sys),
        .nrst                    (nrst),
        .wake_evt                (wake_evt),
        .wake_en                 (wake_en),
        .measure_function_select (measure_function_select),
        .armed                   (mode != SLPRM_INIT && mode != SLPRM_RESTART),
        .flag_clear              (spi_status_clear && !in_restart),
        .wake_hit                (wake_hit),
        .wake_flags              (wake_flags)
    );

    slprm_delay #(.CYC(TRD_CYC)) u_delay (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .run     (in_restart),
        .done    (delay_done)
    );

    // =====================================================
    // mode transitions
    always_comb begin
        next_mode = mode;
        unique case (mode)
            SLPRM_INIT: begin
                if (spi_valid) begin
                    next_mode = SLPRM_NORMAL;
                end
            end
            SLPRM_NORMAL: begin
                if (req_sleep) begin
                    next_mode = (!any_src || |wake_flags) ? SLPRM_RESTART : SLPRM_SLEEP;
                end else if (req_stop) begin
                    next_mode = SLPRM_STOP;
                end
            end
            SLPRM_STOP: begin
                if (req_sleep || req_norm) begin
                    next_mode = req_sleep ? SLPRM_RESTART : SLPRM_NORMAL;
                end
            end
            SLPRM_SLEEP: begin
                if (enter_wake) begin
                    next_mode = SLPRM_RESTART;
                end
            end
            SLPRM_RESTART: begin
                if (delay_done) begin
                    next_mode = SLPRM_NORMAL;
                end
            end
            SLPRM_FSAFE: begin
                if (enter_wake) begin
                    next_mode = SLPRM_RESTART;
                end
            end
        endcase
        if (enter_fault) begin
            next_mode = SLPRM_RESTART;
        end
        if (mode != SLPRM_SLEEP && mode != SLPRM_FSAFE
            && ((watchdog_failure_count_evt && wd_to_fsafe) || ov_fsafe)) begin
            next_mode = SLPRM_FSAFE;
        end
        if (req_soft) begin
            next_mode = SLPRM_INIT;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode <= SLPRM_INIT;
        end else begin
            mode <= next_mode;
        end
    end

    // =====================================================
    // rails, can, reset pin
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            main_supply_rail  <= 1'b1;
            aux_supply_rail   <= 1'b0;
            can_mode          <= SLPRM_CAN_OFF;
            gp_switch_on      <= 1'b0;
            watchdog_enable   <= 1'b1;
            spi_enable        <= 1'b1;
            reset_output_n    <= 1'b0;
            long_window_start <= 1'b0;
            soft_reset        <= 1'b0;
        end else begin
            long_window_start <= in_restart && next_mode == SLPRM_NORMAL;
            soft_reset        <= next_mode == SLPRM_INIT && mode != SLPRM_INIT;
            reset_output_n    <= next_mode != SLPRM_RESTART && next_mode != SLPRM_SLEEP
                                 && next_mode != SLPRM_FSAFE;
            unique case (next_mode)
                SLPRM_SLEEP: begin
                    main_supply_rail <= 1'b0;
                    watchdog_enable  <= 1'b0;
                    spi_enable       <= 1'b0;
                    if (can_mode_cfg != SLPRM_CAN_OFF) begin
                        can_mode <= SLPRM_CAN_WAKE;
                    end
                end
                SLPRM_RESTART: begin
                    main_supply_rail <= 1'b1;
                    aux_supply_rail  <= 1'b0;
                    gp_switch_on     <= 1'b0;
                    watchdog_enable  <= 1'b0;
                    spi_enable       <= 1'b1;
                    if (can_mode != SLPRM_CAN_OFF) begin
                        can_mode <= SLPRM_CAN_WAKE;
                    end
                end
                SLPRM_FSAFE: begin
                    main_supply_rail <= 1'b0;
                    aux_supply_rail  <= 1'b0;
                    gp_switch_on     <= 1'b0;
                    watchdog_enable  <= 1'b0;
                    spi_enable       <= 1'b0;
                    can_mode         <= SLPRM_CAN_WAKE;
                end
                SLPRM_STOP: begin
                    main_supply_rail <= 1'b1;
                end
                default: begin
                    main_supply_rail <= 1'b1;
                    watchdog_enable  <= 1'b1;
                    spi_enable       <= 1'b1;
                    aux_supply_rail  <= aux_rail_cfg;
                    can_mode         <= can_mode_cfg;
                    gp_switch_on     <= gp_switch_mode;
                end
            endcase
        end
    end

    // =====================================================
    // interrupt, spi error
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            interrupt_output_n <= 1'b1;
            spi_fail           <= 1'b0;
        end else begin
            interrupt_output_n <= !((mode == SLPRM_STOP || mode == SLPRM_NORMAL) && |wake_hit
                                    || next_mode == SLPRM_STOP && mode != SLPRM_STOP
                                       && |wake_flags);
            // error on refused sleep; set beats clear
            if ((mode == SLPRM_STOP && spi_valid && spi_write && !allowed)
                || (req_sleep && (mode == SLPRM_STOP || (mode == SLPRM_NORMAL && !any_src)))) begin
                spi_fail <= 1'b1;
            end else if (spi_status_clear && !in_restart) begin
                spi_fail <= 1'b0;
            end
        end
    end

    // =====================================================
    // status and watchdog fields
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            device_status_field         <= SLPRM_DEV_NONE;
            watchdog_failure_count      <= 2'h0;
            main_rail_undervoltage_flag <= 1'b0;
            main_rail_overvoltage_flag  <= 1'b0;
            fail_output                 <= 1'b0;
            watchdog_period             <= SLPRM_WD_PER_DEFAULT;
            mode_bits                   <= SLPRM_REQ_NORMAL;
            wake_status_reg_a           <= '0;
        end else begin
            wake_status_reg_a <= wake_flags;
            if (req_sleep || req_stop) begin
                mode_bits <= spi_mode_code;
            end
            if (next_mode == SLPRM_RESTART && !in_restart) begin
                mode_bits       <= SLPRM_REQ_NORMAL;
                watchdog_period <= SLPRM_WD_PER_DEFAULT;
                device_status_field <= (mode == SLPRM_SLEEP && !enter_fault)
                                       ? SLPRM_DEV_WAKE : SLPRM_DEV_FAULT;
            end
            if (next_mode == SLPRM_FSAFE) begin
                device_status_field <= SLPRM_DEV_FAULT;
            end
            if (watchdog_failure_count_evt && watchdog_failure_count != SLPRM_WDF_TWO) begin
                watchdog_failure_count <= watchdog_failure_count + 2'h1;
            end
            if (uv_evt) begin
                main_rail_undervoltage_flag <= 1'b1;
            end else if (spi_status_clear && !in_restart) begin
                main_rail_undervoltage_flag <= 1'b0;
            end
            if (ov_evt) begin
                main_rail_overvoltage_flag <= 1'b1;
            end else if (spi_status_clear && !in_restart) begin
                main_rail_overvoltage_flag <= 1'b0;
            end
            if (fo_configured
                && ((watchdog_failure_count_evt && cfg1_bit)
                    || (watchdog_failure_count_evt && !cfg1_bit && watchdog_failure_count == SLPRM_WDF_ONE)
                    || (ov_evt && main_rail_overvoltage_reset_enable))) begin
                fail_output <= 1'b1;
            end else if (req_soft) begin
                fail_output <= 1'b0;
            end
        end
    end

    // =====================================================
    // checks
    AST_STOP_NO_MODE: assert property (@(posedge clk_sys) disable iff (!nrst)
        mode == SLPRM_STOP && |wake_hit && !enter_fault && !spi_valid && !watchdog_failure_count_evt
        && !ov_evt |=> mode == SLPRM_STOP && !interrupt_output_n)
        else $error("stop wake changed mode or no interrupt");
    AST_STOP_SLEEP: assert property (@(posedge clk_sys) disable iff (!nrst)
        mode == SLPRM_STOP && req_sleep && !ov_fsafe && !(watchdog_failure_count_evt && wd_to_fsafe)
        |=> mode == SLPRM_RESTART && spi_fail)
        else $error("stop to sleep not refused");
    AST_SLEEP_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
        mode == SLPRM_SLEEP |-> !main_supply_rail && !reset_output_n && !spi_enable)
        else $error("sleep left rail or reset active");
    AST_NO_SRC: assert property (@(posedge clk_sys) disable iff (!nrst)
        mode == SLPRM_NORMAL && req_sleep && !any_src |=> mode != SLPRM_SLEEP)
        else $error("slept with no wake source");
    sequence s_restart_entry;
        !in_restart ##1 in_restart;
    endsequence
    AST_RESTART_EXIT: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_restart_entry ##0 !(uv_evt || ov_evt || watchdog_failure_count_evt || req_soft) [*1]
        |-> ##[1:1000] mode == SLPRM_NORMAL || !in_restart)
        else $error("restart never ended");
    AST_RST_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_restart |-> !reset_output_n)
        else $error("reset released during restart");
    AST_WD_PERIOD: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_restart_entry |-> watchdog_period == SLPRM_WD_PER_DEFAULT)
        else $error("watchdog period not reloaded");
    AST_FO_STICKY: assert property (@(posedge clk_sys) disable iff (!nrst)
        fail_output && !req_soft |=> fail_output)
        else $error("fail output dropped");
    AST_AUX_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_restart |-> !aux_supply_rail && !gp_switch_on)
        else $error("aux rail on in restart");
endmodule : slprm_seq

// ### slprm_host.sv
/* host model: sends decoded spi frames as one-cycle pulses.
 assumes it may only talk while the reset output is high. */
`timescale 1ns/1ns
module slprm_host (
    // system
    input  wire logic       clk_sys,
    input  wire logic       reset_output_n,
    // decoded spi
    output logic       spi_valid,
    output logic       spi_write,
    output logic       spi_is_mode,
    output logic [1:0] spi_mode_code,
    output logic       spi_status_clear
);
    initial {spi_valid, spi_write, spi_is_mode, spi_mode_code, spi_status_clear} = '0;
    // =====================================================
    // one frame: m mode write, c code, k status clear
    task automatic req(input logic m, input logic [1:0] c, input logic k);
        wait (reset_output_n === 1'b1);
        @(negedge clk_sys);
        {spi_valid, spi_write, spi_is_mode, spi_mode_code, spi_status_clear} = {2'h3, m, c, k};
        @(negedge clk_sys);
        {spi_valid, spi_write, spi_is_mode, spi_mode_code, spi_status_clear} = '0;
    endtask : req
endmodule : slprm_host

// ### slprm_seq_test.sv
/* self-checking bench of the mode sequencer.
 assumes slprm_host drives the decoded spi side. */
`timescale 1ns/1ns
module slprm_seq_test import slprm_pkg::*;;
    localparam int TRD = 4;
    logic clk_sys = 0, nrst = 0, spi_valid, spi_write, spi_is_mode, spi_status_clear, spi_fail;
    logic spi_wd_refresh = 0, cyclic_wake_en = 0, measure_function_select = 0, cfg1_bit = 0;
    logic main_rail_overvoltage_reset_enable = 1, config_state_bit = 1, fo_configured = 1;
    logic gp_switch_mode = 1, aux_rail_cfg = 1, uv_evt = 0, ov_evt = 0, watchdog_failure_count_evt = 0;
    logic thermal_shutdown_level2_release = 0, reset_output_n, interrupt_output_n, main_supply_rail, soft_reset;
    logic aux_supply_rail, gp_switch_on, watchdog_enable, spi_enable, long_window_start;
    logic fail_output, main_rail_undervoltage_flag, main_rail_overvoltage_flag;
    logic [1:0] spi_mode_code, can_mode_cfg = 2'h3, can_mode, device_status_field, mode_bits;
    logic [1:0] watchdog_failure_count;
    logic [2:0] watchdog_period;
    logic [3:0] wake_en = 4'hf, wake_evt = 4'h0, wake_status_reg_a;
    logic [7:0] rows [3] = '{8'h88, 8'h54, 8'h31};
    slprm_mode_t mode;
    int err_count = 0, n_tests = 0;
    wire spi_status_access = spi_status_clear;
    slprm_seq #(.TRD_CYC(TRD)) dut (.*);
    slprm_host host (.*);
    initial forever #10 clk_sys = ~clk_sys;
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    // =====================================================
    // row loop, then hand-written low-power cases
    initial begin
        cyc(3);
        chk("rst", {1'b0, SLPRM_WD_PER_DEFAULT, SLPRM_INIT}, {reset_output_n, watchdog_period, mode});
        nrst = 1;
        foreach (rows[i]) begin
            host.req(1, SLPRM_REQ_NORMAL, 1);
            {uv_evt, ov_evt, watchdog_failure_count_evt} = rows[i][7:5];
            cyc(1);
            {uv_evt, ov_evt, watchdog_failure_count_evt} = 3'h0;
            cyc(1);
            chk("enter", {SLPRM_CAN_WAKE, 3'h0, SLPRM_RESTART}, {can_mode, reset_output_n,
                aux_supply_rail, gp_switch_on, mode});
            cyc(TRD - 2);
            chk("hold", {1'b0, SLPRM_RESTART}, {reset_output_n, mode});
            cyc(1);
            chk("back", {2'h3, SLPRM_NORMAL}, {reset_output_n, long_window_start, mode});
            chk("stat", {SLPRM_DEV_FAULT, rows[i][4:0]}, {device_status_field, fail_output,
                main_rail_undervoltage_flag, main_rail_overvoltage_flag,
                watchdog_failure_count});
            chk("per", SLPRM_WD_PER_DEFAULT, watchdog_period);
        end
        host.req(1, SLPRM_REQ_NORMAL, 1);
        host.req(1, SLPRM_REQ_STOP, 0);
        host.req(0, 2'h0, 0);
        chk("stop", {3'h7, SLPRM_REQ_STOP, SLPRM_STOP}, {spi_fail, main_supply_rail,
            aux_supply_rail, mode_bits, mode});
        measure_function_select = 1;
        wake_evt = 4'h2;
        cyc(1);
        chk("meas", 1'b1, interrupt_output_n);
        wake_evt = 4'h1;
        cyc(1);
        wake_evt = 4'h0;
        chk("int", {1'b0, SLPRM_STOP}, {interrupt_output_n, mode});
        measure_function_select = 0;
        host.req(0, 2'h0, 1);
        spi_wd_refresh = 1;
        host.req(0, 2'h0, 0);
        spi_wd_refresh = 0;
        chk("refr", {1'b0, SLPRM_STOP}, {spi_fail, mode});
        host.req(1, SLPRM_REQ_SLEEP, 0);
        chk("stpslp", {3'h4, SLPRM_RESTART}, {spi_fail, mode_bits, mode});
        cyc(TRD + 3);
        wake_en = 4'h0;
        host.req(1, SLPRM_REQ_NORMAL, 1);
        host.req(1, SLPRM_REQ_SLEEP, 0);
        chk("nosrc", {1'b1, SLPRM_RESTART}, {spi_fail, mode});
        cyc(TRD + 3);
        wake_en = 4'h1;
        host.req(1, SLPRM_REQ_NORMAL, 1);
        host.req(1, SLPRM_REQ_SLEEP, 0);
        cyc(1);
        chk("sleep", {SLPRM_CAN_WAKE, 4'h0, SLPRM_SLEEP}, {can_mode, main_supply_rail,
            reset_output_n, watchdog_enable, spi_enable, mode});
        wake_evt = 4'h1;
        cyc(1);
        wake_evt = 4'h0;
        cyc(TRD + 4);
        chk("wake", {SLPRM_DEV_WAKE, 4'h1, SLPRM_NORMAL},
            {device_status_field, wake_status_reg_a, mode});
        host.req(1, SLPRM_REQ_SLEEP, 0);
        chk("stale", {1'b0, SLPRM_RESTART}, {spi_fail, mode});
        cyc(TRD + 3);
        host.req(1, SLPRM_REQ_STOP, 0);
        chk("stint", {1'b0, SLPRM_STOP}, {interrupt_output_n, mode});
        host.req(1, SLPRM_REQ_SOFT, 0);
        chk("soft", {2'h1, SLPRM_INIT}, {fail_output, soft_reset, mode});
        report_and_stop();
    end
    initial begin
        cyc(2000);
        err_count++;
        report_and_stop();
    end
endmodule : slprm_seq_test
